// *** verilog/pmd_regs.svh ***
// register offsets, field positions and timing counts of the peripheral gate
// How it works
// RULE1 - reset clears all disable bits, everything enabled
// RULE2 - set bit puts peripheral in lowest power
// RULE3 - disabled peripheral is held in reset
// RULE4 - disabled registers ignore writes, read zero
// RULE5 - disabled peripheral outputs forced inactive
// RULE6 - clearing bit releases reset, registers at defaults
// RULE7 - software waits two instruction cycles after enable
// RULE8 - bit 7 gates timer 0
// RULE9 - bit 6 gates reference clock output
// RULE10 - bit 5 gates pin change interrupt
// RULE11 - bit 4 gates oscillator tuning
// RULE12 - bit 3 stops peripheral full rate clock
// RULE13 - quarter rate instruction clock keeps running
// RULE14 - bit 2 gates memory scanner
// RULE15 - bit 1 gates checksum unit
// RULE16 - bit 0 blocks nonvolatile access and control writes
// RULE17 - each bit drives reset, select and output masks
`ifndef PMD_REGS_SVH
`define PMD_REGS_SVH

`define CTRL0_INDEX 12'h10c
`define CTRL0_ADDR 12'h430
`define STATUS_INDEX 12'h120
`define STATUS_ADDR 12'h480
`define CTRL0_RESET 8'h00
`define DISABLED_READ 8'h00
`define OUT_INACTIVE 8'h00

`define BIT_TIMER0 7
`define BIT_REFCLK 6
`define BIT_PINCHG 5
`define BIT_OSCTUNE 4
`define BIT_FULLCLK 3
`define BIT_SCANNER 2
`define BIT_CHECKSUM 1
`define BIT_NVACCESS 0

`define LANES 8
`define MCLK_PER_INSTR 4
`define SETTLE_INSTR 2
`define SETTLE_CYC (`SETTLE_INSTR * `MCLK_PER_INSTR)

`endif

// *** verilog/pmd_pkg.sv ***
// types shared by the peripheral gate modules
package pmd_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [3:0] settle_t;
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} bus_state_e;
endpackage

// *** verilog/lane_if.sv ***
// control signals between the gate top and one peripheral lane
`timescale 1ns/1ns
interface lane_if;
	logic off;
	logic hold_rst;
	logic settling;
	modport lane (input off, output hold_rst, output settling);
	modport ctrl (output off, input hold_rst, input settling);
endinterface

// *** verilog/clk_gate_cell.sv ***
// glitch free clock gate for the peripheral full rate clock network
`timescale 1ns/1ns
module clk_gate_cell (
	input wire logic clk,
	input wire logic enable,
	output logic gclk
);
	logic en_l;

	// latch is open while clk is low so the enable never changes inside a high phase
	always_latch
	begin
		if (!clk)
			en_l <= enable;
	end

	assign gclk = clk & en_l;
endmodule

// *** verilog/periph_gate_lane.sv ***
// one peripheral lane: reset hold, register window mask and output mask
`include "pmd_regs.svh"
`timescale 1ns/1ns
module periph_gate_lane (
	input wire logic mclk,
	input wire logic srst,
	lane_if.lane ctl,
	input wire pmd_pkg::byte_t raw_out,
	output pmd_pkg::byte_t gated_out,
	input wire pmd_pkg::byte_t raw_rd,
	output pmd_pkg::byte_t masked_rd,
	input wire logic wr_in,
	output logic wr_out
);
	import pmd_pkg::*;

	logic hold_q, hold_d;
	settle_t settle_q, settle_d;
	byte_t out_q, out_d;

	always_comb
	begin
		hold_d = srst | ctl.off; // RULE3
		settle_d = settle_q;
		if (srst || ctl.off)
			settle_d = settle_t'(`SETTLE_CYC);
		else if (settle_q != 4'h0)
			settle_d = settle_q - 4'h1;
		out_d = ctl.off ? `OUT_INACTIVE : raw_out; // RULE5
	end

	always_ff @(posedge mclk)
	begin
		hold_q <= hold_d;
		settle_q <= srst ? 4'h0 : settle_d;
		out_q <= srst ? `OUT_INACTIVE : out_d;
	end

	// the reset releases one edge after the bit clears, so registers restart at defaults
	assign ctl.hold_rst = hold_q; // RULE6 RULE17
	// settling only flags the window; software is expected to honour it
	assign ctl.settling = settle_q != 4'h0; // RULE7
	assign gated_out = out_q;
	assign masked_rd = ctl.off ? `DISABLED_READ : raw_rd; // RULE4
	assign wr_out = wr_in & ~ctl.off; // RULE4
endmodule

// *** verilog/peripheral_module_gate.sv ***
// peripheral disable control: avalon register slave and per peripheral gating
//
// The Avalon-MM register port was left to the implementer.
`include "pmd_regs.svh"
`timescale 1ns/1ns
module peripheral_module_gate (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] sfr_sel,
	input wire logic sfr_wr,
	input wire logic [63:0] periph_rdata,
	output logic [7:0] periph_wr,
	output pmd_pkg::byte_t core_rdata,
	input wire logic [63:0] periph_out_raw,
	output logic [63:0] periph_out,
	output logic [7:0] periph_rst,
	output logic periph_fullrate_clk,
	output logic instr_clk_en,
	input wire logic nv_rd_req,
	input wire logic nv_wr_req,
	input wire logic nvctrl_wr_req,
	output logic nv_rd_en,
	output logic nv_wr_en,
	output logic nvctrl_wr_en
);
	import pmd_pkg::*;

	bus_state_e state_q, state_d;
	byte_t ctrl0_q, ctrl0_d;
	logic [31:0] rdata_q, rdata_d;
	byte_t core_rd_q, core_rd_d;
	logic [1:0] phase_q, phase_d;
	logic iclk_q, iclk_d;
	logic nv_rd_q, nv_rd_d;
	logic nv_wr_q, nv_wr_d;
	logic nvc_wr_q, nvc_wr_d;
	logic [7:0] settling;
	logic [7:0] lane_wr;
	byte_t masked_rd [`LANES];
	logic req;
	logic hit_ctrl;
	logic hit_status;

	assign req = avs_read | avs_write;
	assign hit_ctrl = avs_address == `CTRL0_ADDR;
	assign hit_status = avs_address == `STATUS_ADDR;

	// register slave: one wait cycle, read data registered for the acknowledge cycle
	always_comb
	begin
		state_d = state_q;
		ctrl0_d = ctrl0_q;
		rdata_d = rdata_q;
		unique case (state_q)
			BUS_IDLE:
			begin
				if (req)
				begin
					state_d = BUS_ACK;
					rdata_d = 32'h0;
					if (avs_read && hit_ctrl)
						rdata_d = {24'h0, ctrl0_q};
					else if (avs_read && hit_status)
						rdata_d = {24'h0, settling};
				end
			end
			BUS_ACK:
			begin
				state_d = BUS_IDLE;
				// bits 7..0 each gate one peripheral group
				if (avs_write && hit_ctrl && avs_byteenable[0])
					ctrl0_d = avs_writedata[7:0]; // RULE2 RULE8 RULE9 RULE10 RULE11 RULE14 RULE15
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state_q <= BUS_IDLE;
			ctrl0_q <= `CTRL0_RESET; // RULE1
			rdata_q <= 32'h0;
		end
		else
		begin
			state_q <= state_d;
			ctrl0_q <= ctrl0_d;
			rdata_q <= rdata_d;
		end
	end

	assign avs_waitrequest = req & (state_q == BUS_IDLE);
	assign avs_readdata = rdata_q;

	genvar g;
	generate
		for (g = 0; g < `LANES; g++)
		begin : lanes
			lane_if ctl ();
			assign ctl.off = ctrl0_q[g]; // RULE17
			assign periph_rst[g] = ctl.hold_rst; // RULE3
			assign settling[g] = ctl.settling;
			assign lane_wr[g] = sfr_wr & sfr_sel[g];
			periph_gate_lane u_lane (
				.mclk(mclk),
				.srst(srst),
				.ctl(ctl),
				.raw_out(periph_out_raw[g*8 +: 8]),
				.gated_out(periph_out[g*8 +: 8]),
				.raw_rd(periph_rdata[g*8 +: 8]),
				.masked_rd(masked_rd[g]),
				.wr_in(lane_wr[g]),
				.wr_out(periph_wr[g])
			);
		end
	endgenerate

	// core read path: registered, disabled windows already forced to zero
	always_comb
	begin
		core_rd_d = 8'h00;
		for (int i = 0; i < `LANES; i++)
		begin
			if (sfr_sel[i])
				core_rd_d = core_rd_d | masked_rd[i]; // RULE4
		end
	end

	// quarter rate instruction strobe never looks at the clock gate bit
	always_comb
	begin
		phase_d = phase_q + 2'h1;
		iclk_d = phase_q == 2'(`MCLK_PER_INSTR - 1); // RULE13
	end

	// nonvolatile access requests are cut while the access bit is set
	always_comb
	begin
		nv_rd_d = nv_rd_req & ~ctrl0_q[`BIT_NVACCESS]; // RULE16
		nv_wr_d = nv_wr_req & ~ctrl0_q[`BIT_NVACCESS]; // RULE16
		nvc_wr_d = nvctrl_wr_req & ~ctrl0_q[`BIT_NVACCESS]; // RULE16
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			core_rd_q <= 8'h00;
			phase_q <= 2'h0;
			iclk_q <= 1'b0;
			nv_rd_q <= 1'b0;
			nv_wr_q <= 1'b0;
			nvc_wr_q <= 1'b0;
		end
		else
		begin
			core_rd_q <= core_rd_d;
			phase_q <= phase_d;
			iclk_q <= iclk_d;
			nv_rd_q <= nv_rd_d;
			nv_wr_q <= nv_wr_d;
			nvc_wr_q <= nvc_wr_d;
		end
	end

	assign core_rdata = core_rd_q;
	assign instr_clk_en = iclk_q;
	assign nv_rd_en = nv_rd_q;
	assign nv_wr_en = nv_wr_q;
	assign nvctrl_wr_en = nvc_wr_q;

	// the gate latch keeps the full rate network free of runt pulses when the bit flips
	clk_gate_cell u_fullclk (
		.clk(mclk),
		.enable(~ctrl0_q[`BIT_FULLCLK]), // RULE12
		.gclk(periph_fullrate_clk)
	);
endmodule

// *** sim/peripheral_module_gate_sva.sv ***
// port checker for the peripheral gate
`timescale 1ns/1ns
module peripheral_module_gate_sva (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [7:0] sfr_sel,
	input wire logic sfr_wr,
	input wire logic [7:0] periph_wr,
	input wire logic [63:0] periph_out,
	input wire logic [7:0] periph_rst,
	input wire logic instr_clk_en,
	input wire logic nv_rd_req,
	input wire logic nv_wr_req,
	input wire logic nv_rd_en,
	input wire logic nv_wr_en
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	// shadow of the control byte, rebuilt from completed bus writes
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (avs_write && !avs_waitrequest && avs_address == 12'h430 && avs_byteenable[0])
			ctrl_d = avs_writedata[7:0];
	end
	always_ff @(posedge mclk)
		ctrl_q <= srst ? 8'h00 : ctrl_d;
	property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_wait: assert property (p_wait) else $error("no bus answer");
	property p_rd; avs_read && !avs_waitrequest && avs_address == 12'h430 |-> avs_readdata == {24'h0, ctrl_q}; endproperty
	a_rd: assert property (p_rd) else $error("control readback");
	property p_wr; periph_wr == (sfr_sel & {8{sfr_wr}} & ~ctrl_q); endproperty
	a_wr: assert property (p_wr) else $error("window write mask");
	property p_rst; periph_rst == ($past(ctrl_q) | {8{$past(srst)}}); endproperty
	a_rst: assert property (p_rst) else $error("reset hold");
	property p_out; ctrl_q[7] && $past(ctrl_q[7]) |-> periph_out[63:56] == 8'h00; endproperty
	a_out: assert property (p_out) else $error("output mask");
	property p_nvr; !$past(srst) |-> nv_rd_en == ($past(nv_rd_req) && !$past(ctrl_q[0])); endproperty
	a_nvr: assert property (p_nvr) else $error("nv read gate");
	property p_nvw; !$past(srst) |-> nv_wr_en == ($past(nv_wr_req) && !$past(ctrl_q[0])); endproperty
	a_nvw: assert property (p_nvw) else $error("nv write gate");
	property p_ins; instr_clk_en |=> !instr_clk_en [*3] ##1 instr_clk_en; endproperty
	a_ins: assert property (p_ins) else $error("instr tick");
	c_ctl: cover property (avs_write && !avs_waitrequest && avs_address == 12'h430);
	c_blk: cover property (sfr_wr && |(sfr_sel & ctrl_q));
	c_nv: cover property (nv_rd_req && ctrl_q[0]);
endmodule
bind peripheral_module_gate peripheral_module_gate_sva u_sva (.*);

// *** sim/periph_model.sv ***
// gated peripherals: one byte register per lane, bumped on each window write
`timescale 1ns/1ns
module periph_model (
	input wire logic mclk,
	input wire logic [7:0] periph_rst,
	input wire logic [7:0] periph_wr,
	output logic [63:0] periph_rdata,
	output logic [63:0] periph_out_raw
);
	logic [63:0] regs_q;
	always_ff @(posedge mclk)
		for (int i = 0; i < 8; i++)
			if (periph_rst[i])
				regs_q[i*8 +: 8] <= 8'h00;
			else if (periph_wr[i])
				regs_q[i*8 +: 8] <= regs_q[i*8 +: 8] + 8'h01;
	assign periph_rdata = regs_q;
	// idle outputs are high so a missing mask shows
	assign periph_out_raw = ~regs_q;
endmodule

// *** sim/peripheral_module_gate_tb.sv ***
// self-checking bench for the peripheral gate
`timescale 1ns/1ns
module peripheral_module_gate_tb;
	logic mclk, srst, avs_read, avs_write, sfr_wr, nv_rd_req, nv_wr_req, nvctrl_wr_req;
	logic avs_waitrequest, periph_fullrate_clk, instr_clk_en, nv_rd_en, nv_wr_en, nvctrl_wr_en;
	logic [11:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic [7:0] sfr_sel, periph_wr, periph_rst;
	logic [7:0] cnt [8];
	logic [63:0] periph_rdata, periph_out_raw, periph_out;
	pmd_pkg::byte_t core_rdata;
	int compares, miscompares, cyc;
	peripheral_module_gate u_dut (.*);
	periph_model u_model (.*);
	initial
	begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wrap_up;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] be,
		output logic [31:0] q);
		@(posedge mclk);
		{avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= {!wr, wr, a, 24'h0, d, be};
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		{avs_read, avs_write} <= 2'b00;
	endtask
	always @(posedge mclk)
		if (++cyc == 20000)
		begin
			miscompares++;
			wrap_up();
		end
	initial
	begin
		logic [31:0] q;
		logic [7:0] v;
		int p;
		{srst, nv_rd_req, nv_wr_req, nvctrl_wr_req} = 4'hf;
		{avs_read, avs_write, avs_address, avs_writedata, avs_byteenable, sfr_sel, sfr_wr} = 0;
		foreach (cnt[i]) cnt[i] = 0;
		p = $urandom(32'hf45f);
		repeat (10) @(posedge mclk);
		srst <= 0;
		bus(0, 12'h430, 0, 4'hf, q); chk(q, 0);
		bus(0, 12'h004, 0, 4'hf, q); chk(q, 0);
		for (int k = 0; k < 24; k++)
		begin
			v = k == 0 ? 8'hff : k == 1 ? 8'h00 : 8'($urandom);
			bus(1, 12'h430, v, 4'hf, q);
			// low byte lane off: must not land
			bus(1, 12'h430, ~v, 4'he, q);
			bus(0, 12'h430, 0, 4'hf, q); chk(q, {24'h0, v});
			foreach (cnt[i]) if (v[i]) cnt[i] = 0;
			p = 0;
			// two instruction cycles of settling before any window access
			repeat (8) begin @(posedge mclk); #1 p += instr_clk_en; end
			chk(p, 2);
			#1 chk(periph_fullrate_clk, !v[3]);
			chk({nv_rd_en, nv_wr_en, nvctrl_wr_en}, {3{!v[0]}});
			// re-enabled lanes have settled by now, disabled lanes still flag
			bus(0, 12'h480, 0, 4'hf, q); chk(q, {24'h0, v});
			for (int n = 0; n < 8; n++)
			begin
				@(posedge mclk);
				sfr_sel <= 8'h01 << n;
				sfr_wr <= 1;
				@(posedge mclk);
				sfr_wr <= 0;
				if (!v[n]) cnt[n]++;
				@(posedge mclk);
				#1 chk(core_rdata, v[n] ? 0 : cnt[n]);
				chk(periph_out[n*8 +: 8], v[n] ? 0 : 8'(~cnt[n]));
				chk(periph_rst[n], v[n]);
			end
		end
		@(posedge mclk) srst <= 1;
		repeat (2) @(posedge mclk);
		srst <= 0;
		bus(0, 12'h430, 0, 4'hf, q); chk(q, 0);
		wrap_up();
	end
endmodule
